// ### rtl/mu_guard_pkg.sv
// constants for the mu delay guard-band search block
package mu_guard_pkg;
   // -----------------------------------------------------------
   // register indices (printed offsets are not multiples of four)
   // -----------------------------------------------------------
   localparam logic [7:0] idx_delay_ctl_one = 8'h2f;
   localparam logic [7:0] idx_duty_cycle = 8'h30;
   localparam logic [7:0] idx_clock_rx_one = 8'h31;
   localparam logic [7:0] idx_search_ctl = 8'h40;
   localparam logic [7:0] idx_search_stat = 8'h41;
   localparam logic [7:0] idx_irq_status = 8'h42;
   localparam logic [7:0] idx_irq_mask = 8'h43;
   localparam logic [7:0] idx_mu_delay = 8'h44;
   // -----------------------------------------------------------
   // field positions and reset values
   // -----------------------------------------------------------
   localparam int guard_lsb = 0;
   localparam int guard_w = 5;
   localparam logic [4:0] guard_rst = 5'h0b;
   localparam int guard_unit_shift = 3;
   localparam int dcc_en_bit = 7;
   localparam logic [7:0] duty_rst = 8'h00;
   localparam logic [7:0] clk_rx_rst = 8'hf0;
   localparam logic [7:0] delay_ctl_rst = 8'h0b;
   localparam int ctl_start_bit = 0;
   localparam int ctl_alt_bit = 1;
   localparam int ctl_retry_bit = 6;
   localparam int ctl_phase_lsb = 8;
   localparam int delay_w = 10;
   localparam logic [9:0] delay_max = 10'h3ff;
   localparam logic [9:0] delay_mid = 10'h200;
   localparam int phase_w = 5;
   localparam int irq_found_bit = 0;
   localparam int irq_fail_bit = 1;
   localparam int irq_w = 2;
   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_step = 2'b01,
      st_cmp = 2'b10
   } search_state_e;
endpackage

// ### rtl/mu_delay_guard_band_search.sv
// mu delay guard-band search with axi4-lite register slave
`timescale 1ns/1ps
// What this block does
// - guard margin counts units of eight codes
// - margin field 0..31, resets to eleven
// - alternating mode steps both directions first
// - after one margin hit, opposite direction only
// - second margin hit without phase: alternate inside
// - reaching delay endpoint declares search failed
// - duty register bit seven enables correction
// - fault policy bit: stop or retry
module mu_delay_guard_band_search (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [4:0] measured_phase,
   output logic [9:0] mu_delay,
   output logic dcc_enable,
   output logic [3:0] neg_leg_common_mode_level,
   output logic irq
);
   // -----------------------------------------------------------
   // registers
   // -----------------------------------------------------------
   logic [7:0] delay_ctl_q; // guard margin in low five bits
   logic [7:0] duty_q; // correction enable plus factory bits
   logic [7:0] clk_rx_q; // neg leg level in upper nibble
   logic alt_mode_q; // search starts alternating when set
   logic retry_q; // fault policy: 1 retries
   logic [4:0] target_q; // desired phase
   logic [1:0] irq_st_q; // sticky events
   logic [1:0] irq_mask_q; // 1 lets event through
   logic [9:0] delay_q; // current mu delay code
   logic [9:0] lo_q; // lowest code visited
   logic [9:0] hi_q; // highest code visited
   logic up_q; // direction of next step
   logic lo_hit_q; // low margin reached
   logic hi_hit_q; // high margin reached
   logic found_q; // phase locked
   logic failed_q; // endpoint reached
   mu_guard_pkg::search_state_e st_q;
   // write channel holding
   logic aw_full_q;
   logic w_full_q;
   logic [7:0] aw_idx_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic [1:0] bresp_q;

   // -----------------------------------------------------------
   // bus decode
   // -----------------------------------------------------------
   wire do_write = aw_full_q && w_full_q && !bvalid_q;
   wire wr_ctl1 = do_write && aw_idx_q == mu_guard_pkg::idx_delay_ctl_one;
   wire wr_duty = do_write && aw_idx_q == mu_guard_pkg::idx_duty_cycle;
   wire wr_clk = do_write && aw_idx_q == mu_guard_pkg::idx_clock_rx_one;
   wire wr_sctl = do_write && aw_idx_q == mu_guard_pkg::idx_search_ctl;
   wire wr_ist = do_write && aw_idx_q == mu_guard_pkg::idx_irq_status;
   wire wr_imask = do_write && aw_idx_q == mu_guard_pkg::idx_irq_mask;
   wire wr_hit = wr_ctl1 | wr_duty | wr_clk | wr_sctl | wr_ist | wr_imask
      | (do_write && aw_idx_q == mu_guard_pkg::idx_search_stat)
      | (do_write && aw_idx_q == mu_guard_pkg::idx_mu_delay);
   wire b0 = w_strb_q[0];
   wire b1 = w_strb_q[1];
   wire start_req = wr_sctl && b0 && w_data_q[mu_guard_pkg::ctl_start_bit];
   wire [7:0] ar_idx = s_axi_araddr[9:2];
   wire rd_go = s_axi_arvalid && !rvalid_q;

   assign s_axi_awready = !aw_full_q;
   assign s_axi_wready = !w_full_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // -----------------------------------------------------------
   // search geometry
   // -----------------------------------------------------------
   // margin in codes: field times eight
   wire [9:0] margin = {2'b00, delay_ctl_q[4:0], 3'b000};
   wire [9:0] lo_lim = margin; // inward from code zero
   wire [9:0] hi_lim = mu_guard_pkg::delay_max - margin;
   wire at_lo_end = delay_q == 10'h000;
   wire at_hi_end = delay_q == mu_guard_pkg::delay_max;
   // judged at the code under compare, so the turn happens right there
   wire lo_reached = delay_q <= lo_lim;
   wire hi_reached = delay_q >= hi_lim;
   // code beyond all visited so far; turning only there widens the walk
   // by one code per side instead of rocking between two codes
   // limitation: a wide alternating walk costs time quadratic in its span
   wire new_ext = up_q ? delay_q > hi_q : delay_q < lo_q;
   wire phase_ok = measured_phase == target_q;
   wire busy = st_q != mu_guard_pkg::st_idle;

   // next direction: alternate in alt mode until a margin is hit, then one-sided
   logic next_up;
   logic next_lo_hit;
   logic next_hi_hit;
   always_comb begin
      next_lo_hit = lo_hit_q | lo_reached;
      next_hi_hit = hi_hit_q | hi_reached;
      if (next_lo_hit && next_hi_hit) begin
         // both margins seen: fall back to alternating inside
         next_up = new_ext ? !up_q : up_q;
      end else if (next_lo_hit) begin
         next_up = 1'b1; // only away from low margin
      end else if (next_hi_hit) begin
         next_up = 1'b0; // only away from high margin
      end else if (alt_mode_q) begin
         next_up = new_ext ? !up_q : up_q; // both directions
      end else begin
         next_up = up_q;
      end
   end

   // -----------------------------------------------------------
   // bus channel handling
   // -----------------------------------------------------------
   // write address and data may arrive in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         aw_idx_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= 2'b00;
      end else begin
         if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            aw_idx_q <= s_axi_awaddr[9:2];
         end
         if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? 2'b00 : 2'b10; // slverr when unmapped
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // read mux, answered one cycle after address is taken
   logic [31:0] rd_mux;
   logic rd_hit;
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case (ar_idx)
         mu_guard_pkg::idx_delay_ctl_one: rd_mux = {24'h0, delay_ctl_q};
         mu_guard_pkg::idx_duty_cycle: rd_mux = {24'h0, duty_q};
         mu_guard_pkg::idx_clock_rx_one: rd_mux = {24'h0, clk_rx_q};
         mu_guard_pkg::idx_search_ctl:
            rd_mux = {19'h0, target_q, 1'b0, retry_q, 4'h0, alt_mode_q, 1'b0};
         mu_guard_pkg::idx_search_stat:
            rd_mux = {27'h0, hi_hit_q, lo_hit_q, failed_q, found_q, busy};
         mu_guard_pkg::idx_irq_status: rd_mux = {30'h0, irq_st_q};
         mu_guard_pkg::idx_irq_mask: rd_mux = {30'h0, irq_mask_q};
         mu_guard_pkg::idx_mu_delay: rd_mux = {22'h0, delay_q};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= 2'b00;
      end else if (rd_go) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= rd_hit ? 2'b00 : 2'b10;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // -----------------------------------------------------------
   // configuration registers
   // -----------------------------------------------------------
   // all codes 0..31 are legal, reset to eleven
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         delay_ctl_q <= mu_guard_pkg::delay_ctl_rst;
         duty_q <= mu_guard_pkg::duty_rst;
         clk_rx_q <= mu_guard_pkg::clk_rx_rst;
         alt_mode_q <= 1'b1;
         retry_q <= 1'b0;
         target_q <= 5'h0e;
         irq_mask_q <= 2'b00;
      end else begin
         if (wr_ctl1 && b0) delay_ctl_q <= w_data_q[7:0];
         // factory bits stored as written; host keeps them
         if (wr_duty && b0) duty_q <= w_data_q[7:0];
         // low nibble reserved, reads zero
         if (wr_clk && b0) clk_rx_q <= {w_data_q[7:4], 4'h0};
         if (wr_sctl && b0) begin
            alt_mode_q <= w_data_q[mu_guard_pkg::ctl_alt_bit];
            retry_q <= w_data_q[mu_guard_pkg::ctl_retry_bit];
         end
         if (wr_sctl && b1) target_q <= w_data_q[12:8];
         if (wr_imask && b0) irq_mask_q <= w_data_q[1:0];
      end
   end

   assign dcc_enable = duty_q[mu_guard_pkg::dcc_en_bit];
   assign neg_leg_common_mode_level = clk_rx_q[7:4];
   assign mu_delay = delay_q;

   // -----------------------------------------------------------
   // search engine
   // -----------------------------------------------------------
   // step one code, then compare a cycle later so phase settles
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= mu_guard_pkg::st_idle;
         delay_q <= mu_guard_pkg::delay_mid;
         lo_q <= mu_guard_pkg::delay_mid;
         hi_q <= mu_guard_pkg::delay_mid;
         up_q <= 1'b1;
         lo_hit_q <= 1'b0;
         hi_hit_q <= 1'b0;
         found_q <= 1'b0;
         failed_q <= 1'b0;
      end else begin
         case (st_q)
            mu_guard_pkg::st_idle: begin
               if (start_req) begin
                  st_q <= mu_guard_pkg::st_cmp;
                  lo_q <= delay_q;
                  hi_q <= delay_q;
                  lo_hit_q <= 1'b0;
                  hi_hit_q <= 1'b0;
                  found_q <= 1'b0;
                  failed_q <= 1'b0;
               end
            end
            mu_guard_pkg::st_step: begin
               // one code per step
               delay_q <= up_q ? delay_q + 10'h001 : delay_q - 10'h001;
               st_q <= mu_guard_pkg::st_cmp;
            end
            mu_guard_pkg::st_cmp: begin
               if (up_q && delay_q > hi_q) hi_q <= delay_q;
               if (!up_q && delay_q < lo_q) lo_q <= delay_q;
               if (phase_ok) begin
                  found_q <= 1'b1;
                  st_q <= mu_guard_pkg::st_idle;
               end else if (at_lo_end || at_hi_end) begin
                  // endpoint means failure; retry restarts from mid
                  failed_q <= 1'b1;
                  if (retry_q) begin
                     delay_q <= mu_guard_pkg::delay_mid;
                     lo_q <= mu_guard_pkg::delay_mid;
                     hi_q <= mu_guard_pkg::delay_mid;
                     lo_hit_q <= 1'b0;
                     hi_hit_q <= 1'b0;
                     st_q <= mu_guard_pkg::st_cmp;
                  end else begin
                     st_q <= mu_guard_pkg::st_idle; // stop on error
                  end
               end else begin
                  lo_hit_q <= next_lo_hit;
                  hi_hit_q <= next_hi_hit;
                  up_q <= next_up;
                  st_q <= mu_guard_pkg::st_step;
               end
            end
            default: st_q <= mu_guard_pkg::st_idle;
         endcase
      end
   end

   // -----------------------------------------------------------
   // interrupts
   // -----------------------------------------------------------
   wire ev_found = st_q == mu_guard_pkg::st_cmp && phase_ok;
   wire ev_fail = st_q == mu_guard_pkg::st_cmp && !phase_ok && (at_lo_end || at_hi_end);
   wire [1:0] ev = {ev_fail, ev_found};
   wire [1:0] clr = (wr_ist && b0) ? w_data_q[1:0] : 2'b00;
   // set beats a clear landing in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) irq_st_q <= 2'b00;
      else irq_st_q <= (irq_st_q & ~clr) | ev;
   end
   assign irq = |(irq_st_q & irq_mask_q);
endmodule

// ### tb/mu_guard_assertions.sv
// port assertions for the guard-band search block
`timescale 1ns/1ps
module mu_guard_assertions (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [9:0] mu_delay,
   input wire logic dcc_enable,
   input wire logic [3:0] neg_leg_common_mode_level
);
   // ----
   // decode helpers
   // ----
   wire logic wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire logic wr_low = wr_take && s_axi_wstrb[0] && s_axi_awaddr[31:10] == 22'h0;
   wire logic rd_take = s_axi_arvalid && s_axi_arready;
   wire logic [7:0] ridx = s_axi_araddr[9:2];
   // misaligned low bits are ignored by the slave
   // upper address bits are not decoded by the slave either
   wire logic mapped =
      (ridx inside {8'h2f, 8'h30, 8'h31, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44});
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ----
   // assertions
   // ----
   // endpoints excluded: a retry may jump back to mid range
   chk_delay_one_step: assert property (
      $past(mu_delay) != 10'h0 && $past(mu_delay) != 10'h3ff |->
      10'(mu_delay - $past(mu_delay) + 10'h1) <= 10'h2)
      else $error("mu delay moved more than one code");
   chk_duty_write: assert property (
      wr_low && s_axi_awaddr[9:2] == 8'h30 |-> ##2 dcc_enable == $past(s_axi_wdata[7], 2))
      else $error("correction enable does not follow write");
   chk_neg_leg_write: assert property (
      wr_low && s_axi_awaddr[9:2] == 8'h31 |-> ##2
      neg_leg_common_mode_level == $past(s_axi_wdata[7:4], 2))
      else $error("negative leg level does not follow write");
   chk_bvalid_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   chk_rvalid_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
      else $error("read response dropped early");
   // write lands and response rises on the same edge, two edges after take
   chk_write_answer: assert property (wr_take |-> ##2 s_axi_bvalid)
      else $error("no write response two cycles after take");
   chk_read_answer: assert property (rd_take |=> s_axi_rvalid)
      else $error("no read data one cycle after take");
   chk_read_resp_code: assert property (
      rd_take |=> s_axi_rresp == ($past(mapped) ? 2'b00 : 2'b10))
      else $error("read response code wrong for address");
   chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("address accepted while read data pending");
   // main scenarios reached
   cover property (wr_low && s_axi_awaddr[9:2] == 8'h30);
   cover property (rd_take && !mapped);
   cover property (mu_delay == 10'h0 || mu_delay == 10'h3ff);
endmodule
bind mu_delay_guard_band_search mu_guard_assertions i_chk (.aclk, .aresetn, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mu_delay, .dcc_enable,
   .neg_leg_common_mode_level);

// ### tb/phase_source.sv
// phase measurement source at the far side of the search block
`timescale 1ns/1ps
module phase_source #(
   parameter logic [9:0] hit_code = 10'h205, // code where the wanted phase shows
   parameter logic [4:0] hit_phase = 5'h0e // wanted phase, the target after reset
) (
   input wire logic aclk,
   input wire logic [9:0] mu_delay,
   input wire logic hit_en,
   output logic [4:0] measured_phase
);
   logic flip_q = 1'b0; // varies the miss value so no stale value lingers
   // free toggle, a crude stand-in for measurement noise
   always_ff @(posedge aclk) begin
      flip_q <= !flip_q;
   end
   // a miss is never equal to the wanted phase
   assign measured_phase = (hit_en && mu_delay == hit_code) ? hit_phase :
      hit_phase ^ {flip_q, 3'b000, 1'b1};
endmodule

// ### tb/tb.sv
// self-checking bench for the mu delay guard-band search block
`timescale 1ns/1ps
module tb;
   logic aclk = 1'b0, aresetn = 1'b0, hit_en = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [3:0] s_axi_wstrb = 4'h3; // both low bytes, wide enough for every field
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic dcc_enable, irq;
   logic [4:0] measured_phase, g;
   logic [9:0] mu_delay, d;
   logic [3:0] neg_leg_common_mode_level, nl;
   logic [1:0] exp_b[$]; // noted write responses
   logic [33:0] exp_r[$]; // noted reads as {resp, data}
   int n_mismatch = 0, comparisons = 0;
   always #2 aclk = !aclk;
   mu_delay_guard_band_search i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .measured_phase, .mu_delay,
      .dcc_enable, .neg_leg_common_mode_level, .irq);
   phase_source i_phase (.aclk, .mu_delay, .hit_en, .measured_phase);
   // ----
   // shared tasks
   // ----
   task automatic check(input logic [33:0] got, input logic [33:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // sampled at the falling edge, where the handshake is settled
   always @(negedge aclk) begin
      if (s_axi_bvalid && s_axi_bready) check(34'(s_axi_bresp), 34'(exp_b.pop_front()), "bresp");
      if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, exp_r.pop_front(), "rd");
   end
   // write with both channels offered together; ready raised late at random
   task automatic wr(input logic [7:0] idx, input logic [31:0] v, input logic [1:0] r);
      logic ta, tw, bv;
      exp_b.push_back(r);
      @(posedge aclk);
      s_axi_awaddr <= {22'h0, idx, 2'b00};
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'($urandom);
      do begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         bv = s_axi_bvalid && s_axi_bready;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         s_axi_bready <= !bv;
      end while (!bv);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [33:0] e);
      logic ta, rv;
      exp_r.push_back(e);
      @(posedge aclk);
      s_axi_araddr <= {22'h0, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'($urandom);
      do begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         rv = s_axi_rvalid && s_axi_rready;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
         s_axi_rready <= !rv;
      end while (!rv);
   endtask
   task automatic wait_irq(input logic v);
      for (int i = 0; i < 5000 && irq !== v; i++) @(posedge aclk);
      check(34'(irq), 34'(v), "irq");
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ----
   // tests
   // ----
   initial begin
      void'($urandom(32'h14ef));
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h2f, 34'h0b);
      rd(8'h30, 34'h00);
      rd(8'h31, 34'hf0);
      check(34'(neg_leg_common_mode_level), 34'hf, "nleg");
      check(34'(dcc_enable), 34'h0, "dcc");
      $display("test reset values done");
      // both ends of the margin field, then a random one
      for (int i = 0; i < 3; i++) begin
         g = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom);
         wr(8'h2f, 32'(g), 2'b00);
         rd(8'h2f, 34'(g));
      end
      $display("test margin field done");
      nl = 4'($urandom);
      wr(8'h30, 32'h80, 2'b00);
      check(34'(dcc_enable), 34'h1, "dcc on");
      rd(8'h30, 34'h80);
      wr(8'h31, {24'h0, nl, 4'h0}, 2'b00);
      check(34'(neg_leg_common_mode_level), 34'(nl), "nleg");
      rd(8'h31, {26'h0, nl, 4'h0});
      wr(8'h31, 32'hf0, 2'b00);
      check(34'(neg_leg_common_mode_level), 34'hf, "nleg rec");
      wr(8'h30, 32'h0, 2'b00);
      check(34'(dcc_enable), 34'h0, "dcc off");
      wr(8'h10, 32'h5a, 2'b10);
      rd(8'h10, 34'h200000000);
      $display("test control fields done");
      // wanted phase inside the band, found interrupt unmasked
      hit_en <= 1'b1;
      wr(8'h2f, 32'h0b, 2'b00);
      wr(8'h30, 32'h80, 2'b00);
      wr(8'h43, 32'h1, 2'b00);
      wr(8'h40, 32'h0e03, 2'b00);
      wait_irq(1'b1);
      check(34'(mu_delay), 34'h205, "found code");
      rd(8'h42, 34'h1);
      wr(8'h42, 32'h1, 2'b00);
      wait_irq(1'b0);
      $display("test search found done");
      // zero margin puts it on the endpoints; stop on fault
      hit_en <= 1'b0;
      wr(8'h43, 32'h0, 2'b00);
      wr(8'h2f, 32'h0, 2'b00);
      // straight walk: alternating over the whole range would take too long
      wr(8'h40, 32'h0e01, 2'b00);
      for (int i = 0; i < 5000 && mu_delay !== 10'h0 && mu_delay !== 10'h3ff; i++) begin
         @(posedge aclk);
      end
      d = mu_delay;
      repeat (20) @(posedge aclk);
      check(34'(mu_delay), 34'(d), "stopped");
      check(34'(irq), 34'h0, "masked");
      rd(8'h42, 34'h2);
      wr(8'h43, 32'h2, 2'b00);
      wait_irq(1'b1);
      wr(8'h42, 32'h2, 2'b00);
      wait_irq(1'b0);
      $display("test search fail done");
      // retry on fault: fails at the top end, restarts at mid, walks up
      hit_en <= 1'b1;
      wr(8'h43, 32'h1, 2'b00);
      wr(8'h40, 32'h0e41, 2'b00);
      wait_irq(1'b1);
      check(34'(mu_delay), 34'h205, "retry found");
      rd(8'h41, 34'h6);
      rd(8'h42, 34'h3);
      $display("test search retry done");
      give_verdict();
   end
   // watchdog well beyond the longest search
   initial begin
      #200000;
      n_mismatch++;
      $display("[ERR] %0t watchdog expired", $time);
      give_verdict();
   end
endmodule
